// ===== logic/lsm_unit.sv
// Purpose: logic, rotate, shift, swap, multiply, divide, bcd adjust execution
// Assumes: operands supplied by the core; one state per clock
// Notes:
`include "lsm_cfg.svh"
module lsm_unit
  import lsm_pkg::*;
(
  input  wire logic        clk,        // core clock, 100 MHz
  input  wire logic        rst,        // async reset, active high
  input  wire logic        clkEn,      // freezes all state when low
  input  wire logic        start,      // launch one operation
  input  wire lsm_op_type  op,         // operation
  input  wire lsm_src_type srcKind,    // operand addressing
  input  wire lsm_loc_type rdLoc,      // where a direct/ext operand lives
  input  wire lsm_loc_type wrLoc,      // where a direct result goes
  input  wire logic        wide,       // word operands when high
  input  wire logic        srcMode,    // source encoding mode when high
  input  wire logic [3:0]  waitStates, // configured external wait states N
  input  wire logic [15:0] opDest,     // destination operand
  input  wire logic [15:0] opSrc,      // source operand
  input  wire logic        carryIn,    // current carry flag
  input  wire logic        halfCarryIn,// current half-carry flag
  output logic             busy,       // operation in progress
  output logic             done,       // one-cycle result strobe
  output logic [31:0]      result,     // result, extended for mul/div
  output logic             carryOut,   // new carry flag
  output logic             carryWr,    // carry flag is updated
  output logic [4:0]       states      // states the operation took
);
  typedef struct packed {
    lsm_state_type fsm;
    logic [4:0]    cnt;
    logic [4:0]    total;
    logic [31:0]   res;
    logic          cy;
    logic          cyWr;
    logic          isDiv;
    logic          wide;
  } lsm_core_type;
  lsm_core_type state_reg, state_next;

  lsm_div_if div();

  lsm_divider u_div (
    .clk   (clk),
    .rst   (rst),
    .clkEn (clkEn),
    .div   (div)
  );

  function automatic logic [4:0] pick(input logic s, input logic [4:0] b, input logic [4:0] x);
    return s ? x : b;
  endfunction

  function automatic logic [4:0] extra(input lsm_loc_type l, input logic [4:0] p,
                                       input logic [4:0] f);
    logic [4:0] e;
    e = 5'h00;
    case (l)
      LSM_LOC_PORT: e = p;
      LSM_LOC_SFR:  e = f;
      default:      e = 5'h00;
    endcase
    return e;
  endfunction

  logic [4:0]  baseStates;
  logic [4:0]  addStates;
  logic [4:0]  extOne;
  logic [15:0] logicRes;
  logic [31:0] opRes;
  logic        opCy;
  logic        opCyWr;
  logic [7:0]  bcdLo;
  logic [8:0]  bcdHi;

  // limitation: states is 5 bits, so a word long direct external operand with N above 11 (above 12 in source mode) wraps the count
  assign extOne = 5'({1'b0, waitStates}) + `LSM_EXT_BASE;

  // base state counts by operation and operand shape
  always_comb begin
    baseStates = `LSM_ST_ACC;
    case (op)
      LSM_AND, LSM_OR, LSM_XOR: begin
        case (srcKind)
          LSM_SRC_REG:    baseStates = wide ? pick(srcMode, `LSM_ST_WREG_BIN, `LSM_ST_WREG_SRC)
                                            : pick(srcMode, `LSM_ST_BREG_BIN, `LSM_ST_BREG_SRC);
          LSM_SRC_IMM:    baseStates = wide ? pick(srcMode, `LSM_ST_WIMM_BIN, `LSM_ST_WIMM_SRC)
                                            : pick(srcMode, `LSM_ST_BIMM_BIN, `LSM_ST_BIMM_SRC);
          LSM_SRC_DIRIMM: baseStates = `LSM_ST_DIRIMM;
          LSM_SRC_IND24:  baseStates = pick(srcMode, `LSM_ST_DRK_BIN, `LSM_ST_DRK_SRC);
          default:        baseStates = wide ? pick(srcMode, `LSM_ST_WIMM_BIN, `LSM_ST_WIMM_SRC)
                                            : pick(srcMode, `LSM_ST_BIMM_BIN, `LSM_ST_BIMM_SRC);
        endcase
      end
      LSM_SLL, LSM_SRA, LSM_SRL:
        baseStates = pick(srcMode, `LSM_ST_SHIFT_BIN, `LSM_ST_SHIFT_SRC);
      LSM_SWAP: baseStates = `LSM_ST_SWAP;
      LSM_MUL:  baseStates = wide ? pick(srcMode, `LSM_ST_WMUL_BIN, `LSM_ST_WMUL_SRC)
                                  : pick(srcMode, `LSM_ST_BMUL_BIN, `LSM_ST_BMUL_SRC);
      LSM_DIV:  baseStates = wide ? pick(srcMode, `LSM_ST_WDIV_BIN, `LSM_ST_WDIV_SRC)
                                  : pick(srcMode, `LSM_ST_BDIV_BIN, `LSM_ST_BDIV_SRC);
      default:  baseStates = `LSM_ST_ACC;
    endcase
  end

  // access penalties for direct and external operands
  always_comb begin
    addStates = 5'h00;
    if (op == LSM_AND || op == LSM_OR || op == LSM_XOR) begin
      if (srcKind == LSM_SRC_SHORT_DIRECT_ADDRESS && !wide)
        addStates = extra(rdLoc, `LSM_ADD_RD_PORT, `LSM_ADD_RD_SFR);
      if (srcKind == LSM_SRC_DIRIMM)
        addStates = extra(wrLoc, `LSM_ADD_WR_PORT, `LSM_ADD_WR_SFR);
      if (rdLoc == LSM_LOC_EXT && srcKind != LSM_SRC_SHORT_DIRECT_ADDRESS && srcKind != LSM_SRC_DIRIMM)
        addStates = (wide && srcKind == LSM_SRC_LONG_DIRECT_ADDRESS) ? 5'(extOne << 1)
                                                       : extOne;
    end
  end

  always_comb begin
    logicRes = 16'h0000;
    case (op)
      LSM_AND: logicRes = opDest & opSrc;
      LSM_OR:  logicRes = opDest | opSrc;
      default: logicRes = opDest ^ opSrc;
    endcase
    if (!wide) logicRes[15:8] = 8'h00;
  end

  always_comb begin
    bcdLo = opDest[7:0];
    if (opDest[3:0] > `LSM_BCD_LIMIT || halfCarryIn)
      bcdLo = opDest[7:0] + {4'h0, `LSM_BCD_FIX};
    bcdHi = {1'b0, bcdLo};
    if (bcdLo[7:4] > `LSM_BCD_LIMIT || carryIn)
      bcdHi = {1'b0, bcdLo} + {1'b0, `LSM_BCD_FIX, 4'h0};
  end

  always_comb begin
    opRes  = 32'h0000_0000;
    opCy   = carryIn;
    opCyWr = 1'b0;
    case (op)
      LSM_AND, LSM_OR, LSM_XOR: opRes = {16'h0000, logicRes};
      LSM_ZERO: opRes = 32'h0000_0000;
      LSM_INV:  opRes = {24'h000000, ~opDest[7:0]};
      LSM_ROL:  opRes = {24'h000000, opDest[6:0], opDest[7]};
      LSM_ROLC: begin
        opRes  = {24'h000000, opDest[6:0], carryIn};
        opCy   = opDest[7];
        opCyWr = 1'b1;
      end
      LSM_ROR:  opRes = {24'h000000, opDest[0], opDest[7:1]};
      LSM_RORC: begin
        opRes  = {24'h000000, carryIn, opDest[7:1]};
        opCy   = opDest[0];
        opCyWr = 1'b1;
      end
      LSM_SLL: begin
        opRes  = wide ? {16'h0000, opDest[14:0], 1'b0} : {24'h000000, opDest[6:0], 1'b0};
        opCy   = wide ? opDest[15] : opDest[7];
        opCyWr = 1'b1;
      end
      LSM_SRA: begin
        opRes  = wide ? {16'h0000, opDest[15], opDest[15:1]}
                      : {24'h000000, opDest[7], opDest[7:1]};
        opCy   = opDest[0];
        opCyWr = 1'b1;
      end
      LSM_SRL: begin
        opRes  = wide ? {16'h0000, 1'b0, opDest[15:1]} : {24'h000000, 1'b0, opDest[7:1]};
        opCy   = opDest[0];
        opCyWr = 1'b1;
      end
      LSM_SWAP: opRes = {24'h000000, opDest[3:0], opDest[7:4]};
      LSM_MUL: begin
        // carry cleared as the core does for multiply
        // widen before multiplying so the product keeps its upper half
        opRes  = wide ? (32'(opDest) * 32'(opSrc))
                      : {16'h0000, 16'(opDest[7:0]) * 16'(opSrc[7:0])};
        opCy   = 1'b0;
        opCyWr = 1'b1;
      end
      LSM_BCD: begin
        opRes  = {24'h000000, bcdHi[7:0]};
        opCy   = carryIn | bcdHi[8];
        opCyWr = 1'b1;
      end
      default: begin
        opRes  = 32'h0000_0000;
        opCy   = 1'b0;
        opCyWr = 1'b1;
      end
    endcase
  end

  assign div.start    = clkEn && start && state_reg.fsm != LSM_BUSY && op == LSM_DIV;
  assign div.dividend = wide ? opDest : {8'h00, opDest[7:0]};
  assign div.divisor  = wide ? opSrc : {8'h00, opSrc[7:0]};
  assign div.wide     = wide;

  always_comb begin
    state_next = state_reg;
    case (state_reg.fsm)
      LSM_IDLE, LSM_DONE: begin
        state_next.fsm = LSM_IDLE;
        if (start) begin
          state_next.total = baseStates + addStates;
          state_next.cnt   = baseStates + addStates - 5'h01;
          state_next.res   = opRes;
          state_next.cy    = opCy;
          state_next.cyWr  = opCyWr;
          state_next.isDiv = (op == LSM_DIV);
          state_next.wide  = wide;
          state_next.fsm   = (baseStates + addStates == 5'h01) ? LSM_DONE : LSM_BUSY;
        end
      end
      LSM_BUSY: begin
        state_next.cnt = state_reg.cnt - 5'h01;
        if (state_reg.cnt == 5'h01) begin
          state_next.fsm = LSM_DONE;
          if (state_reg.isDiv) begin
            // quotient to the high part, remainder to the low part
            state_next.res = state_reg.wide ? {div.quotient, div.remainder}
                                            : {16'h0000, div.quotient[7:0], div.remainder[7:0]};
            state_next.cy  = 1'b0;
          end
        end
      end
      default: state_next.fsm = LSM_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '{fsm: LSM_IDLE, default: '0};
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  assign busy     = (state_reg.fsm == LSM_BUSY);
  assign done     = (state_reg.fsm == LSM_DONE);
  assign result   = state_reg.res;
  assign carryOut = state_reg.cy;
  assign carryWr  = state_reg.cyWr;
  assign states   = state_reg.total;

  property p_swap_time;
    @(posedge clk) disable iff (rst)
    (clkEn && start && !busy && op == LSM_SWAP) ##1 clkEn |-> busy ##1 done;
  endproperty
  a_swap_time: assert property (p_swap_time) else $error("swap not two states");

  property p_rolc;
    @(posedge clk) disable iff (rst)
    (clkEn && start && !busy && op == LSM_ROLC) |=> (done && carryOut == $past(opDest[7])
      && result[0] == $past(carryIn));
  endproperty
  a_rolc: assert property (p_rolc) else $error("rotate left via carry wrong");

  property p_rorc;
    @(posedge clk) disable iff (rst)
    (clkEn && start && !busy && op == LSM_RORC) |=> (carryOut == $past(opDest[0])
      && result[7] == $past(carryIn));
  endproperty
  a_rorc: assert property (p_rorc) else $error("rotate right via carry wrong");

  property p_sra;
    @(posedge clk) disable iff (rst)
    (clkEn && start && !busy && op == LSM_SRA && !wide) |=>
      (result[7] == $past(opDest[7]) && carryOut == $past(opDest[0]));
  endproperty
  a_sra: assert property (p_sra) else $error("arith shift right wrong");

  property p_srl;
    @(posedge clk) disable iff (rst)
    (clkEn && start && !busy && op == LSM_SRL && !wide) |=>
      (result[7:0] == {1'b0, $past(opDest[7:1])} && carryOut == $past(opDest[0]));
  endproperty
  a_srl: assert property (p_srl) else $error("logical shift right wrong");

  // word long direct external operand: base 4 plus 2(N+2), binary mode
  property p_ext_word;
    @(posedge clk) disable iff (rst)
    (clkEn && start && !busy && (op == LSM_AND || op == LSM_OR || op == LSM_XOR) && wide
      && srcKind == LSM_SRC_LONG_DIRECT_ADDRESS && rdLoc == LSM_LOC_EXT && !srcMode)
      |=> states == {$past(waitStates), 1'b0} + 5'h08;
  endproperty
  a_ext_word: assert property (p_ext_word) else $error("word external penalty wrong");

  property p_wdiv_time;
    @(posedge clk) disable iff (rst)
    (clkEn && start && !busy && op == LSM_DIV && wide)
      |=> states == ($past(srcMode) ? 5'h14 : 5'h15);
  endproperty
  a_wdiv_time: assert property (p_wdiv_time) else $error("word divide count wrong");

  property p_states_count;
    @(posedge clk) disable iff (rst)
    (clkEn && start && !busy && op == LSM_MUL && wide && !srcMode && rdLoc == LSM_LOC_NONE)
      |=> states == 5'h0C;
  endproperty
  a_states_count: assert property (p_states_count) else $error("word multiply not 12");

  property p_breg;
    @(posedge clk) disable iff (rst)
    (clkEn && start && !busy && op == LSM_AND && srcKind == LSM_SRC_REG && !wide && srcMode)
      |=> (done && result[7:0] == ($past(opDest[7:0]) & $past(opSrc[7:0])));
  endproperty
  a_breg: assert property (p_breg) else $error("byte and in source mode wrong");

  property p_wr_sfr;
    @(posedge clk) disable iff (rst)
    (clkEn && start && !busy && op == LSM_OR && srcKind == LSM_SRC_DIRIMM && wrLoc == LSM_LOC_SFR)
      |=> states == 5'h06;
  endproperty
  a_wr_sfr: assert property (p_wr_sfr) else $error("sfr write penalty wrong");

  property p_done_pulse;
    @(posedge clk) disable iff (rst)
    (done && clkEn && !start) |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held too long");
endmodule

// ===== logic/lsm_cfg.svh
// Purpose: constants for the logic, shift and multiply/divide unit
// Assumes: one state is one clock cycle at 100 MHz
// Notes:   timing counts are in states
`ifndef LSM_CFG_SVH
`define LSM_CFG_SVH
`define LSM_ST_BREG_BIN     5'h02
`define LSM_ST_BREG_SRC     5'h01
`define LSM_ST_WREG_BIN     5'h03
`define LSM_ST_WREG_SRC     5'h02
`define LSM_ST_WIMM_BIN     5'h04
`define LSM_ST_WIMM_SRC     5'h03
`define LSM_ST_BIMM_BIN     5'h03
`define LSM_ST_BIMM_SRC     5'h02
`define LSM_ST_DIRIMM       5'h03
`define LSM_ST_DRK_BIN      5'h04
`define LSM_ST_DRK_SRC      5'h03
`define LSM_ST_ACC          5'h01
`define LSM_ST_SHIFT_BIN    5'h02
`define LSM_ST_SHIFT_SRC    5'h01
`define LSM_ST_SWAP         5'h02
`define LSM_ST_BMUL_BIN     5'h06
`define LSM_ST_BMUL_SRC     5'h05
`define LSM_ST_WMUL_BIN     5'h0C
`define LSM_ST_WMUL_SRC     5'h0B
`define LSM_ST_BDIV_BIN     5'h0B
`define LSM_ST_BDIV_SRC     5'h0A
`define LSM_ST_WDIV_BIN     5'h15
`define LSM_ST_WDIV_SRC     5'h14
`define LSM_ADD_RD_PORT     5'h01
`define LSM_ADD_RD_SFR      5'h02
`define LSM_ADD_WR_PORT     5'h02
`define LSM_ADD_WR_SFR      5'h03
`define LSM_EXT_BASE        5'h02
`define LSM_BCD_LIMIT       4'h9
`define LSM_BCD_FIX         4'h6
`define LSM_BUS_CMD_NO      2'h0
`define LSM_BUS_CMD_PORT    2'h1
`define LSM_BUS_CMD_SFR     2'h2
`endif

// ===== logic/lsm_pkg.sv
// Purpose: types for the logic, shift and multiply/divide unit
// Assumes: included config header for numbers
// Notes:   operations and operand shapes
package lsm_pkg;
  typedef enum logic [4:0] {
    LSM_AND = 5'h00, LSM_OR = 5'h01, LSM_XOR = 5'h02, LSM_ZERO = 5'h03,
    LSM_INV = 5'h04, LSM_ROL = 5'h05, LSM_ROLC = 5'h06, LSM_ROR = 5'h07,
    LSM_RORC = 5'h08, LSM_SLL = 5'h09, LSM_SRA = 5'h0A, LSM_SRL = 5'h0B,
    LSM_SWAP = 5'h0C, LSM_MUL = 5'h0D, LSM_DIV = 5'h0E, LSM_BCD = 5'h0F
  } lsm_op_type;
  typedef enum logic [2:0] {
    LSM_SRC_REG = 3'h0, LSM_SRC_IMM = 3'h1, LSM_SRC_SHORT_DIRECT_ADDRESS = 3'h2,
    LSM_SRC_LONG_DIRECT_ADDRESS = 3'h3, LSM_SRC_IND16 = 3'h4, LSM_SRC_IND24 = 3'h5,
    LSM_SRC_DIRIMM = 3'h6
  } lsm_src_type;
  typedef enum logic [1:0] {
    LSM_LOC_NONE = 2'h0, LSM_LOC_PORT = 2'h1, LSM_LOC_SFR = 2'h2, LSM_LOC_EXT = 2'h3
  } lsm_loc_type;
  typedef enum logic [2:0] {
    LSM_IDLE = 3'b001, LSM_BUSY = 3'b010, LSM_DONE = 3'b100
  } lsm_state_type;
endpackage

// ===== logic/lsm_div_if.sv
// Purpose: link between the unit and its divider
// Assumes: one clock
// Notes:   start is a pulse, result stands until next start
interface lsm_div_if;
  logic        start;
  logic [15:0] dividend;
  logic [15:0] divisor;
  logic        wide;
  logic [15:0] quotient;
  logic [15:0] remainder;
  modport core (output start, dividend, divisor, wide, input quotient, remainder);
  modport unit (input start, dividend, divisor, wide, output quotient, remainder);
endinterface

// ===== logic/lsm_divider.sv
// Purpose: unsigned divider for byte and word operands
// Assumes: inputs stable during start
// Notes:   zero divisor gives all-ones quotient, remainder = dividend
module lsm_divider
  import lsm_pkg::*;
(
  input wire logic clk,       // core clock
  input wire logic rst,       // async reset
  input wire logic clkEn,     // freeze when low
  lsm_div_if.unit  div        // divide request and result
);
  typedef struct packed {
    logic [15:0] quo;
    logic [15:0] rem;
  } lsm_div_state_type;
  lsm_div_state_type state_reg, state_next;

  function automatic logic [31:0] divide(input logic [15:0] a, input logic [15:0] b,
                                         input logic w);
    logic [15:0] q;
    logic [15:0] r;
    q = 16'hFFFF;
    r = a;
    if (b != 16'h0000) begin
      q = a / b;
      r = a % b;
    end
    // byte quotients stay eight bits wide, so a zero divisor gives FF, not FFFF
    if (!w) q[15:8] = 8'h00;
    return {q, r};
  endfunction

  always_comb begin
    state_next = state_reg;
    if (div.start) begin
      // single-cycle divide; the unit stretches time to the documented count
      {state_next.quo, state_next.rem} = divide(div.dividend, div.divisor, div.wide);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  assign div.quotient  = state_reg.quo;
  assign div.remainder = state_reg.rem;
endmodule

// ===== test/tb_lsm_unit.sv
// Purpose: self-checking bench for the logic, shift and multiply/divide unit
// Assumes: one state per enabled clock edge; done marks the last state
// Notes:   counts run from the taking edge to the edge that raises done
module tb_lsm_unit import lsm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam lsm_loc_type LN = LSM_LOC_NONE;
  localparam lsm_loc_type LP = LSM_LOC_PORT;
  localparam lsm_loc_type LS = LSM_LOC_SFR;
  localparam lsm_loc_type LE = LSM_LOC_EXT;
  logic        clk, rst, clkEn, start, wide, srcMode, carryIn, halfCarryIn;
  logic        busy, done, carryOut, carryWr, holdStart;
  lsm_op_type  op;
  lsm_src_type srcKind;
  lsm_loc_type rdLoc, wrLoc;
  logic [3:0]  waitStates;
  logic [15:0] opDest, opSrc;
  logic [31:0] result;
  logic [4:0]  states;
  int          n_mismatch, samples_checked, stall;

  lsm_unit dut (.clk(clk), .rst(rst), .clkEn(clkEn), .start(start), .op(op),
    .srcKind(srcKind), .rdLoc(rdLoc), .wrLoc(wrLoc), .wide(wide), .srcMode(srcMode),
    .waitStates(waitStates), .opDest(opDest), .opSrc(opSrc), .carryIn(carryIn),
    .halfCarryIn(halfCarryIn), .busy(busy), .done(done), .result(result),
    .carryOut(carryOut), .carryWr(carryWr), .states(states));

  always #5 clk = ~clk;

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // ec < 0 leaves the carry unchecked; stall freezes clkEn right after the take
  task automatic run_op(lsm_op_type o, lsm_src_type k, lsm_loc_type rl, lsm_loc_type wl,
      logic w, logic m, logic [3:0] n, logic [15:0] d, logic [15:0] s, logic ci,
      logic hi, logic [31:0] er, int ec, int et);
    int cnt;
    @(posedge clk);
    op <= o;
    srcKind <= k;
    rdLoc <= rl;
    wrLoc <= wl;
    wide <= w;
    srcMode <= m;
    waitStates <= n;
    opDest <= d;
    opSrc <= s;
    carryIn <= ci;
    halfCarryIn <= hi;
    start <= '1;
    @(posedge clk);
    // the take edge is the first state; holding start must be ignored while busy
    start <= holdStart;
    clkEn <= (stall == 0);
    cnt = 1;
    #1;
    while (done !== 1'b1 && cnt < 60) begin
      @(posedge clk);
      cnt++;
      start <= '0;
      if (cnt > stall) clkEn <= '1;
      #1;
    end
    check(done, 1);
    if (done !== 1'b1) wrap_up();
    check(cnt, et + stall);
    check(states, et);
    check(result, er);
    if (ec >= 0) begin
      check(carryWr, 1);
      check(carryOut, ec);
    end
  endtask

  task automatic s_logic;
    lsm_op_type  ops[3] = '{LSM_AND, LSM_OR, LSM_XOR};
    logic [15:0] d = 16'hA5C3;
    logic [15:0] s = 16'h0FF0;
    logic [15:0] r;
    for (int i = 0; i < 3; i++) begin
      r = (i == 0) ? (d & s) : (i == 1) ? (d | s) : (d ^ s);
      for (int m = 0; m < 2; m++) begin
        run_op(ops[i], LSM_SRC_REG, LN, LN, '0, m[0], '0, d, s, '0, '0,
               {24'h0, r[7:0]}, -1, 2 - m);
        run_op(ops[i], LSM_SRC_REG, LN, LN, '1, m[0], '0, d, s, '0, '0,
               {16'h0, r}, -1, 3 - m);
        run_op(ops[i], LSM_SRC_IMM, LN, LN, '1, m[0], '0, d, s, '0, '0,
               {16'h0, r}, -1, 4 - m);
        run_op(ops[i], LSM_SRC_IMM, LN, LN, '0, m[0], '0, d, s, '0, '0,
               {24'h0, r[7:0]}, -1, 3 - m);
      end
    end
  endtask

  task automatic s_direct;
    lsm_loc_type locs[3] = '{LN, LP, LS};
    int          radd[3] = '{0, 1, 2};
    int          wadd[3] = '{0, 2, 3};
    for (int j = 0; j < 3; j++) begin
      for (int m = 0; m < 2; m++) begin
        run_op(LSM_OR, LSM_SRC_DIRIMM, LN, locs[j], '0, m[0], '0, 16'h0011,
               16'h0042, '0, '0, 32'h53, -1, 3 + wadd[j]);
        run_op(LSM_AND, LSM_SRC_SHORT_DIRECT_ADDRESS, locs[j], LN, '0, m[0], '0, 16'h00F3,
               16'h003C, '0, '0, 32'h30, -1, 3 - m + radd[j]);
      end
    end
  endtask

  task automatic s_ext;
    int nv[2] = '{0, 11};
    for (int i = 0; i < 2; i++) begin
      for (int m = 0; m < 2; m++) begin
        run_op(LSM_XOR, LSM_SRC_LONG_DIRECT_ADDRESS, LE, LN, '0, m[0], 4'(nv[i]), 16'h00FF,
               16'h000F, '0, '0, 32'hF0, -1, 3 - m + nv[i] + 2);
        run_op(LSM_XOR, LSM_SRC_LONG_DIRECT_ADDRESS, LE, LN, '1, m[0], 4'(nv[i]), 16'hFF00,
               16'h0FF0, '0, '0, 32'hF0F0, -1, 4 - m + 2 * (nv[i] + 2));
        run_op(LSM_OR, LSM_SRC_IND24, LE, LN, '0, m[0], 4'(nv[i]), 16'h0001,
               16'h0080, '0, '0, 32'h81, -1, 4 - m + nv[i] + 2);
        run_op(LSM_OR, LSM_SRC_IND16, LE, LN, '0, m[0], 4'(nv[i]), 16'h0001,
               16'h0080, '0, '0, 32'h81, -1, 3 - m + nv[i] + 2);
      end
      run_op(LSM_OR, LSM_SRC_IND24, LN, LN, '0, nv[i] != 0, '0, 16'h0001,
             16'h0080, '0, '0, 32'h81, -1, (nv[i] != 0) ? 3 : 4);
    end
  endtask

  task automatic s_rotate;
    lsm_op_type aops[4] = '{LSM_ZERO, LSM_INV, LSM_ROL, LSM_ROR};
    logic [7:0] aexp[4] = '{8'h00, 8'h7E, 8'h03, 8'hC0};
    // these leave the carry alone, so carryWr must stay low
    for (int i = 0; i < 4; i++) begin
      run_op(aops[i], LSM_SRC_REG, LN, LN, '0, '0, '0, 16'h0081, '0, '1, '0,
             {24'h0, aexp[i]}, -1, 1);
      check(carryWr, 0);
    end
    for (int c = 0; c < 2; c++) begin
      run_op(LSM_ROLC, LSM_SRC_REG, LN, LN, '0, c[0], '0, 16'h0041, '0, c[0], '0,
             {24'h0, 7'h41, c[0]}, 0, 1);
      run_op(LSM_RORC, LSM_SRC_REG, LN, LN, '0, c[0], '0, 16'h0041, '0, c[0], '0,
             {24'h0, c[0], 7'h20}, 1, 1);
    end
  endtask

  task automatic s_shift;
    lsm_op_type  ops[3] = '{LSM_SLL, LSM_SRA, LSM_SRL};
    logic [7:0]  bexp[3] = '{8'h02, 8'hC0, 8'h40};
    logic [15:0] wexp[3] = '{16'h8004, 16'h2001, 16'h2001};
    for (int i = 0; i < 3; i++) begin
      for (int m = 0; m < 2; m++) begin
        run_op(ops[i], LSM_SRC_REG, LN, LN, '0, m[0], '0, 16'h0081, '0, '0, '0,
               {24'h0, bexp[i]}, 1, 2 - m);
        run_op(ops[i], LSM_SRC_REG, LN, LN, '1, m[0], '0, 16'h4002, '0, '1, '0,
               {16'h0, wexp[i]}, 0, 2 - m);
      end
    end
  endtask

  task automatic s_swap;
    for (int m = 0; m < 2; m++) begin
      // first run unstalled so the timing assertion sees it, second with clkEn frozen
      stall = 3 * m;
      run_op(LSM_SWAP, LSM_SRC_REG, LN, LN, '0, m[0], '0, 16'h003C, '0, '0, '0,
             32'hC3, -1, 2);
    end
    stall = 0;
  endtask

  task automatic s_muldiv;
    holdStart = '1;
    for (int m = 0; m < 2; m++) begin
      run_op(LSM_MUL, LSM_SRC_REG, LN, LN, '0, m[0], '0, 16'h12FF, 16'h34FF, '1, '0,
             32'hFE01, 0, 6 - m);
      run_op(LSM_MUL, LSM_SRC_REG, LN, LN, '1, m[0], '0, 16'hFFFF, 16'hFFFF, '1, '0,
             32'hFFFE0001, 0, 12 - m);
      run_op(LSM_DIV, LSM_SRC_REG, LN, LN, '0, m[0], '0, 16'h00C8, 16'h0007, '1, '0,
             32'h1C04, 0, 11 - m);
      run_op(LSM_DIV, LSM_SRC_REG, LN, LN, '1, m[0], '0, 16'hFFFF, 16'h0100, '1, '0,
             32'h00FF00FF, 0, 21 - m);
      run_op(LSM_DIV, LSM_SRC_REG, LN, LN, '0, m[0], '0, 16'h005A, 16'h0000, '1, '0,
             32'hFF5A, 0, 11 - m);
    end
    holdStart = '0;
  endtask

  task automatic s_bcd;
    // fields: input byte, carry, half-carry, adjusted byte, new carry
    logic [27:0] tv[5] = '{28'h09010F0, 28'h1210721, 28'hA300031, 28'h4500450, 28'h2B00310};
    for (int i = 0; i < 5; i++) begin
      run_op(LSM_BCD, LSM_SRC_REG, LN, LN, '0, '0, '0, {8'h0, tv[i][27:20]}, '0,
             tv[i][16], tv[i][12], {24'h0, tv[i][11:4]}, int'(tv[i][0]), 1);
    end
  endtask

  initial begin
    clk = '0;
    rst = '1;
    clkEn = '1;
    start = '0;
    op = LSM_AND;
    srcKind = LSM_SRC_REG;
    rdLoc = LN;
    wrLoc = LN;
    wide = '0;
    srcMode = '0;
    waitStates = '0;
    opDest = '0;
    opSrc = '0;
    carryIn = '0;
    halfCarryIn = '0;
    holdStart = '0;
    stall = 0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    rst <= '0;
    @(posedge clk);
    #1;
    // every output starts at zero out of reset
    check(result, 0);
    check(states, 0);
    check({busy, done, carryOut, carryWr}, 0);
    s_logic();
    s_direct();
    s_ext();
    s_rotate();
    s_shift();
    s_swap();
    s_muldiv();
    s_bcd();
    wrap_up();
  end
endmodule
